// *** inc/ddchb_params.svh ***
`ifndef DDCHB_PARAMS_SVH
`define DDCHB_PARAMS_SVH

// ============================================================
// Register map
`define DDCHB_CTRL_ADDR      12'h000
`define DDCHB_STATUS_ADDR    12'h004
`define DDCHB_COUNT_ADDR     12'h008
`define DDCHB_CTRL_RESET     8'h00
`define DDCHB_CTRL_MASK      8'hCB
`define DDCHB_RATIO_LSB      0
`define DDCHB_RATIO_MSB      1
`define DDCHB_C2R_BIT        3
`define DDCHB_GAIN_BIT       6
`define DDCHB_CPLX_IN_BIT    7
`define DDCHB_RESP_OKAY      2'h0
`define DDCHB_RESP_SLVERR    2'h2

// ============================================================
// Ratio field codes and decimation figures
`define DDCHB_CODE_DEC4      2'h0
`define DDCHB_CODE_DEC8      2'h1
`define DDCHB_CODE_DEC16     2'h2
`define DDCHB_DEC1           5'h01
`define DDCHB_DEC2           5'h02
`define DDCHB_DEC4           5'h04
`define DDCHB_DEC8           5'h08
`define DDCHB_DEC16          5'h10

// ============================================================
// Stage shapes and coefficients
`define DDCHB_DATA_W         16
`define DDCHB_MAX_SIDE       14
`define DDCHB_FIRST_TAPS     7
`define DDCHB_FIRST_NSIDE    2
`define DDCHB_FIRST_SIDE     '{0: -32'sd512, 1: 32'sd4608, default: 32'sd0}
`define DDCHB_FIRST_CENTRE   32'sd8192
`define DDCHB_FIRST_SHIFT    14
`define DDCHB_SECOND_TAPS    11
`define DDCHB_SECOND_NSIDE   3
`define DDCHB_SECOND_SIDE    '{0: 32'sd859, 1: -32'sd6661, 2: 32'sd38570, default: 32'sd0}
`define DDCHB_SECOND_CENTRE  32'sd65536
`define DDCHB_SECOND_SHIFT   17
`define DDCHB_THIRD_TAPS     19
`define DDCHB_THIRD_NSIDE    5
`define DDCHB_THIRD_SIDE     '{0: 32'sd161, 1: -32'sd1328, 2: 32'sd5814, 3: -32'sd19272, \
                               4: 32'sd80160, default: 32'sd0}
`define DDCHB_THIRD_CENTRE   32'sd131072
`define DDCHB_THIRD_SHIFT    18
`define DDCHB_FINAL_TAPS     55
`define DDCHB_FINAL_NSIDE    14
`define DDCHB_FINAL_SIDE     '{-32'sd24, 32'sd102, -32'sd302, 32'sd730, -32'sd1544, \
                               32'sd2964, -32'sd5284, 32'sd8903, -32'sd14383, 32'sd22640, \
                               -32'sd35476, 32'sd57468, -32'sd105442, 32'sd331792}
`define DDCHB_FINAL_CENTRE   32'sd524288
`define DDCHB_FINAL_SHIFT    20

`endif

// *** inc/ddchb_pkg.sv ***
`include "ddchb_params.svh"

package ddchb_pkg;
    typedef logic signed [31:0] ddchb_coef_type;
    typedef ddchb_coef_type     ddchb_coef_list_type [`DDCHB_MAX_SIDE];
endpackage : ddchb_pkg

// *** inc/ddchb_stream_if.sv ***
`include "ddchb_params.svh"

interface ddchb_stream_if #(
    parameter int DATA_W = `DDCHB_DATA_W
);
    logic                     valid;
    logic signed [DATA_W-1:0] i;
    logic signed [DATA_W-1:0] q;
    modport source (output valid, output i, output q);
    modport sink   (input valid, input i, input q);
endinterface : ddchb_stream_if

// *** tb/ddchb_src.sv ***
module ddchb_src (
    input  wire logic        aclk,
    output logic             in_valid,
    output logic [15:0]      in_i,
    output logic [15:0]      in_q
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        in_valid = 1'b0;
        in_i = 16'h0000;
        in_q = 16'h0000;
    end
    // One sample every gap+1 cycles; data lines flip while idle
    task automatic send(input int n, input int gap, input logic [15:0] i, input logic [15:0] q);
        repeat (n) begin
            @(posedge aclk);
            in_valid <= 1'b1;
            in_i <= i;
            in_q <= q;
            repeat (gap) begin
                @(posedge aclk);
                in_valid <= 1'b0;
                in_i <= ~i;
                in_q <= ~q;
            end
        end
        @(posedge aclk);
        in_valid <= 1'b0;
        in_i <= ~i;
        in_q <= ~q;
    endtask : send
endmodule : ddchb_src

// *** tb/tb_ddc_halfband_decimation_chain.sv ***
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module tb_ddc_halfband_decimation_chain;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, in_valid, out_valid, mixer_complex_in;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [15:0] in_i, in_q, out_i, out_q, last_i, last_q, ei, eq;
    logic [7:0]  c;
    int error_cnt = 0, samples_checked = 0, n_out = 0, exp_cnt = 0, n0, t;
    // Real-input settings carry the 6 dB gain; complex ones may add it for weak signals
    logic [7:0] cfg [9] = '{8'h80, 8'h41, 8'h82, 8'h43, 8'h88, 8'h49, 8'h8A, 8'h8B, 8'hC3};
    int dec [4] = '{4, 8, 16, 2};
    logic [3:0] msk [4] = '{4'hC, 4'hE, 4'hF, 4'h8};
    ddchb_chain DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .in_valid, .in_i, .in_q, .out_valid, .out_i, .out_q, .mixer_complex_in);
    ddchb_src SRC (.aclk, .in_valid, .in_i, .in_q);
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) if (out_valid) begin
        n_out <= n_out + 1;
        last_i <= out_i;
        last_q <= out_q;
    end
    // ============================================================
    // Bus tasks
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic pa, pw, ta, tw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa || pw) begin
            @(negedge aclk);
            ta = pa && s_axi_awready;
            tw = pw && s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        do begin
            @(negedge aclk);
            ta = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge aclk);
        end while (!ta);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [11:0] a);
        logic tk;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            tk = s_axi_arready;
            @(posedge aclk);
        end while (!tk);
        s_axi_arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            tk = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
        end while (!tk);
        s_axi_rready <= 1'b0;
    endtask : rdr
    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run
    // ============================================================
    // Tests
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(12'h000);
        `CHK("ctrl reset", 32'h0000_0000, rd)
        rdr(12'h004);
        `CHK("status reset", 32'h0000_004C, rd)
        for (int k = 0; k < 9; k++) begin
            c = cfg[k];
            wr(12'h000, {24'h00_0000, c});
            rdr(12'h004);
            t = dec[c[1:0]] >> c[3];
            `CHK("status", {23'h00_0000, t[4:0], msk[c[1:0]]}, rd)
            n0 = n_out;
            SRC.send(64, k % 2, 16'h03E8, 16'hFE0C);
            repeat (40) @(posedge aclk);
            `CHK("outputs", 64 / t, n_out - n0)
            exp_cnt += 64 / t;
            `CHK("mixer type", c[7], mixer_complex_in)
            if (c[1:0] == 2'h3) begin
                ei = c[3] ? (c[6] ? 16'hFC18 : 16'hFE0C) : (c[6] ? 16'h07D0 : 16'h03E8);
                eq = c[3] ? 16'h0000 : (c[6] ? 16'hFC18 : 16'hFE0C);
                `CHK("out i", ei, last_i)
                `CHK("out q", eq, last_q)
            end
        end
        wr(12'h004, 32'h0000_0003);
        `CHK("ro write", 2'h2, rsp)
        wr(12'h00C, 32'h0000_0003);
        `CHK("unmapped write", 2'h2, rsp)
        rdr(12'h00C);
        `CHK("unmapped resp", 2'h2, rsp)
        `CHK("unmapped data", 32'h0000_0000, rd)
        s_axi_wstrb <= 4'hE;
        wr(12'h000, 32'h0000_0000);
        `CHK("no strobe resp", 2'h0, rsp)
        s_axi_wstrb <= 4'hF;
        rdr(12'h000);
        `CHK("ctrl kept", 32'h0000_00C3, rd)
        rdr(12'h008);
        `CHK("count", exp_cnt, rd)
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        complete_run();
    end
endmodule : tb_ddc_halfband_decimation_chain

// *** verilog/ddchb_chain.sv ***
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`include "ddchb_params.svh"

module ddchb_chain #(
    parameter int DATA_W = `DDCHB_DATA_W
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output wire logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output wire logic              s_axi_wready,
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [11:0]       s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output wire logic              s_axi_arready,
    output logic      [31:0]       s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              in_valid,
    input  wire logic [DATA_W-1:0] in_i,
    input  wire logic [DATA_W-1:0] in_q,
    output logic                   out_valid,
    output logic      [DATA_W-1:0] out_i,
    output logic      [DATA_W-1:0] out_q,
    output wire logic              mixer_complex_in
);
    import ddchb_pkg::*;

    // ============================================================
    // Register slave
    logic [7:0]  ctrl;
    logic        aw_held;
    logic        w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [31:0] sample_count;
    logic [31:0] status_word;

    wire logic        wr_go     = aw_held && w_held;
    wire logic [11:0] wr_word   = {aw_addr[11:2], 2'b00};
    wire logic        wr_ctrl   = wr_word == `DDCHB_CTRL_ADDR;
    wire logic [11:0] rd_word   = {s_axi_araddr[11:2], 2'b00};
    wire logic        rd_ctrl   = rd_word == `DDCHB_CTRL_ADDR;
    wire logic        rd_status = rd_word == `DDCHB_STATUS_ADDR;
    wire logic        rd_count  = rd_word == `DDCHB_COUNT_ADDR;
    wire logic        rd_hit    = rd_ctrl || rd_status || rd_count;
    wire logic [31:0] rd_data   = rd_ctrl   ? {24'h00_0000, ctrl} :
                                  rd_status ? status_word :
                                  rd_count  ? sample_count : 32'h0000_0000;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `DDCHB_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ctrl ? `DDCHB_RESP_OKAY : `DDCHB_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Ratio, output type, gain and input type fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `DDCHB_CTRL_RESET;
        end else if (wr_go && wr_ctrl && w_strb[0]) begin
            ctrl <= w_data[7:0] & `DDCHB_CTRL_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `DDCHB_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= rd_hit ? `DDCHB_RESP_OKAY : `DDCHB_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ============================================================
    // Stage selection
    wire logic [1:0] ratio_code = ctrl[`DDCHB_RATIO_MSB:`DDCHB_RATIO_LSB];
    wire logic       c2r_on     = ctrl[`DDCHB_C2R_BIT];
    wire logic       gain_on    = ctrl[`DDCHB_GAIN_BIT];
    wire logic [4:0] filt_ratio = ratio_code == `DDCHB_CODE_DEC4  ? `DDCHB_DEC4 :
                                  ratio_code == `DDCHB_CODE_DEC8  ? `DDCHB_DEC8 :
                                  ratio_code == `DDCHB_CODE_DEC16 ? `DDCHB_DEC16 : `DDCHB_DEC2;
    wire logic [4:0] total_dec  = c2r_on ? filt_ratio >> 1 : filt_ratio;
    wire logic       first_on   = c2r_on ? total_dec == `DDCHB_DEC8
                                         : total_dec == `DDCHB_DEC16;
    wire logic       second_on  = c2r_on ?
        (total_dec == `DDCHB_DEC4 || total_dec == `DDCHB_DEC8) :
        (total_dec == `DDCHB_DEC8 || total_dec == `DDCHB_DEC16);
    wire logic       third_on   = c2r_on ?
        (total_dec == `DDCHB_DEC2 || total_dec == `DDCHB_DEC4 || total_dec == `DDCHB_DEC8) :
        (total_dec == `DDCHB_DEC4 || total_dec == `DDCHB_DEC8 || total_dec == `DDCHB_DEC16);

    assign mixer_complex_in = ctrl[`DDCHB_CPLX_IN_BIT];
    assign status_word      = {{23{1'b0}}, total_dec, 1'b1, third_on, second_on, first_on};

    // ============================================================
    // Filter cascade
    ddchb_stream_if #(.DATA_W(DATA_W)) s_in ();
    ddchb_stream_if #(.DATA_W(DATA_W)) s_first ();
    ddchb_stream_if #(.DATA_W(DATA_W)) s_second ();
    ddchb_stream_if #(.DATA_W(DATA_W)) s_third ();
    ddchb_stream_if #(.DATA_W(DATA_W)) s_final ();

    assign s_in.valid = in_valid;
    assign s_in.i     = in_i;
    assign s_in.q     = in_q;

    // Fixed order: first, second, third, final
    ddchb_stage #(
        .DATA_W (DATA_W),
        .NTAPS  (`DDCHB_FIRST_TAPS),
        .NSIDE  (`DDCHB_FIRST_NSIDE),
        .SIDE   (`DDCHB_FIRST_SIDE),
        .CENTRE (`DDCHB_FIRST_CENTRE),
        .SHIFT  (`DDCHB_FIRST_SHIFT)
    ) u_first_halfband_stage (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .enable   (first_on),
        .no_decim (1'b0),
        .up       (s_in),
        .dn       (s_first)
    );

    ddchb_stage #(
        .DATA_W (DATA_W),
        .NTAPS  (`DDCHB_SECOND_TAPS),
        .NSIDE  (`DDCHB_SECOND_NSIDE),
        .SIDE   (`DDCHB_SECOND_SIDE),
        .CENTRE (`DDCHB_SECOND_CENTRE),
        .SHIFT  (`DDCHB_SECOND_SHIFT)
    ) u_second_halfband_stage (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .enable   (second_on),
        .no_decim (1'b0),
        .up       (s_first),
        .dn       (s_second)
    );

    ddchb_stage #(
        .DATA_W (DATA_W),
        .NTAPS  (`DDCHB_THIRD_TAPS),
        .NSIDE  (`DDCHB_THIRD_NSIDE),
        .SIDE   (`DDCHB_THIRD_SIDE),
        .CENTRE (`DDCHB_THIRD_CENTRE),
        .SHIFT  (`DDCHB_THIRD_SHIFT)
    ) u_third_halfband_stage (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .enable   (third_on),
        .no_decim (1'b0),
        .up       (s_second),
        .dn       (s_third)
    );

    ddchb_stage #(
        .DATA_W (DATA_W),
        .NTAPS  (`DDCHB_FINAL_TAPS),
        .NSIDE  (`DDCHB_FINAL_NSIDE),
        .SIDE   (`DDCHB_FINAL_SIDE),
        .CENTRE (`DDCHB_FINAL_CENTRE),
        .SHIFT  (`DDCHB_FINAL_SHIFT)
    ) u_final_halfband_stage (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .enable   (1'b1),
        .no_decim (c2r_on),
        .up       (s_third),
        .dn       (s_final)
    );

    // ============================================================
    // Gain stage and quarter-rate mixer
    logic                     gain_valid;
    logic signed [DATA_W-1:0] gain_i;
    logic signed [DATA_W-1:0] gain_q;
    logic [1:0]               rot;

    function automatic logic signed [DATA_W-1:0] dbl(input logic signed [DATA_W-1:0] x);
        if (x[DATA_W-1] != x[DATA_W-2]) begin
            dbl = {x[DATA_W-1], {(DATA_W-1){~x[DATA_W-1]}}};
        end else begin
            dbl = {x[DATA_W-2:0], 1'b0};
        end
    endfunction : dbl

    function automatic logic signed [DATA_W-1:0] neg(input logic signed [DATA_W-1:0] x);
        if (x == {1'b1, {(DATA_W-1){1'b0}}}) begin
            neg = {1'b0, {(DATA_W-1){1'b1}}};
        end else begin
            neg = -x;
        end
    endfunction : neg

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gain_valid <= 1'b0;
            gain_i     <= '0;
            gain_q     <= '0;
        end else begin
            gain_valid <= s_final.valid;
            gain_i     <= gain_on ? dbl(s_final.i) : s_final.i;
            gain_q     <= gain_on ? dbl(s_final.q) : s_final.q;
        end
    end

    // Rotation by j^n; only the real part is kept
    always_ff @(posedge aclk) begin
        if (!aresetn || !c2r_on) begin
            rot <= 2'h0;
        end else if (gain_valid) begin
            rot <= rot + 2'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_valid <= 1'b0;
            out_i     <= '0;
            out_q     <= '0;
        end else begin
            out_valid <= gain_valid;
            if (!c2r_on) begin
                out_i <= gain_i;
            end else begin
                case (rot)
                    2'h0:    out_i <= gain_i;
                    2'h1:    out_i <= neg(gain_q);
                    2'h2:    out_i <= neg(gain_i);
                    default: out_i <= gain_q;
                endcase
            end
            out_q <= c2r_on ? '0 : gain_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_count <= 32'h0000_0000;
        end else if (out_valid) begin
            sample_count <= sample_count + 32'h0000_0001;
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    sequence s_rot_step;
        c2r_on && gain_valid && rot == 2'h1 ##1 c2r_on;
    endsequence

    a_first_stage_sel: assert property (
        first_on == (ratio_code == `DDCHB_CODE_DEC16))
        else $error("first stage selection wrong");
    a_second_stage_sel: assert property (
        second_on == (ratio_code == `DDCHB_CODE_DEC8 || ratio_code == `DDCHB_CODE_DEC16))
        else $error("second stage selection wrong");
    a_third_stage_sel: assert property (
        third_on == (ratio_code != 2'h3))
        else $error("third stage selection wrong");
    a_stage_order: assert property (
        (first_on |-> second_on) and (second_on |-> third_on))
        else $error("stage cascade order broken");
    a_gain_double: assert property (
        gain_on && s_final.valid && s_final.i[DATA_W-1] == s_final.i[DATA_W-2]
        |=> gain_valid && gain_i == DATA_W'($past(s_final.i) * 2))
        else $error("6 dB gain not applied");
    a_real_q_drop: assert property (
        out_valid && $past(c2r_on) |-> out_q == '0)
        else $error("quadrature not dropped in real mode");
    a_mixer_rotation: assert property (
        s_rot_step |-> out_i == neg($past(gain_q)))
        else $error("quarter-rate mixer step wrong");
    a_write_answer: assert property (
        s_write_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
endmodule : ddchb_chain

// *** verilog/ddchb_stage.sv ***
`include "ddchb_params.svh"

module ddchb_stage #(
    parameter int                            DATA_W = `DDCHB_DATA_W,
    parameter int                            NTAPS  = 11,
    parameter int                            NSIDE  = 3,
    parameter ddchb_pkg::ddchb_coef_list_type SIDE  = '{default: 32'sd0},
    parameter ddchb_pkg::ddchb_coef_type     CENTRE = 32'sd0,
    parameter int                            SHIFT  = 17
) (
    input  wire logic      aclk,
    input  wire logic      aresetn,
    input  wire logic      enable,
    input  wire logic      no_decim,
    ddchb_stream_if.sink   up,
    ddchb_stream_if.source dn
);
    import ddchb_pkg::*;

    localparam int ACC_W = DATA_W + 36;

    logic signed [DATA_W-1:0] tap_i [NTAPS];
    logic signed [DATA_W-1:0] tap_q [NTAPS];
    logic                     phase;
    logic                     fire;
    logic [1:0]               in_since;

    function automatic logic signed [ACC_W-1:0] tap(input logic use_q, input int idx);
        tap = use_q ? ACC_W'(tap_q[idx]) : ACC_W'(tap_i[idx]);
    endfunction : tap

    // Only even taps and the centre are multiplied; the other odd taps are zero
    function automatic logic signed [DATA_W-1:0] mac(input logic use_q);
        logic signed [ACC_W-1:0] acc;
        acc = ACC_W'(CENTRE) * tap(use_q, (NTAPS - 1) / 2);
        for (int k = 0; k < NSIDE; k++) begin
            acc = acc + ACC_W'(SIDE[k]) * (tap(use_q, 2 * k) + tap(use_q, NTAPS - 1 - 2 * k));
        end
        acc = (acc + (ACC_W'(1) <<< (SHIFT - 1))) >>> SHIFT;
        if (&acc[ACC_W-1:DATA_W-1] || ~|acc[ACC_W-1:DATA_W-1]) begin
            mac = acc[DATA_W-1:0];
        end else begin
            mac = {acc[ACC_W-1], {(DATA_W-1){~acc[ACC_W-1]}}};
        end
    endfunction : mac

    // ============================================================
    // Delay lines, one each for the I and Q paths
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int k = 0; k < NTAPS; k++) begin
                tap_i[k] <= '0;
                tap_q[k] <= '0;
            end
        end else if (up.valid) begin
            tap_i[0] <= up.i;
            tap_q[0] <= up.q;
            for (int k = 1; k < NTAPS; k++) begin
                tap_i[k] <= tap_i[k-1];
                tap_q[k] <= tap_q[k-1];
            end
        end
    end

    // ============================================================
    // Decimation phase
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= 1'b0;
            fire  <= 1'b0;
        end else begin
            fire <= up.valid && enable && (phase || no_decim);
            if (up.valid || !enable) begin
                phase <= enable && !no_decim && !phase;
            end
        end
    end

    // ============================================================
    // Output register: filter or bypass
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dn.valid <= 1'b0;
            dn.i     <= '0;
            dn.q     <= '0;
        end else begin
            dn.valid <= enable ? fire : up.valid;
            dn.i     <= enable ? mac(1'b0) : up.i;
            dn.q     <= enable ? mac(1'b1) : up.q;
        end
    end

    // ============================================================
    // Checks
    always_ff @(posedge aclk) begin
        if (!aresetn || !enable || no_decim) begin
            in_since <= 2'h0;
        end else if (fire) begin
            in_since <= {1'b0, up.valid};
        end else if (up.valid && in_since != 2'h3) begin
            in_since <= in_since + 2'h1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_nd_input;
        enable && no_decim && up.valid ##1 enable && no_decim;
    endsequence

    a_half_rate_out: assert property (
        $rose(fire) && enable && !no_decim |-> $past(in_since) == 2'h1)
        else $error("stage fired without two inputs");
    a_bypass_copy: assert property (
        !enable && up.valid |=> dn.valid && dn.i == $past(up.i) && dn.q == $past(up.q))
        else $error("bypass did not pass sample through");
    a_no_decim_rate: assert property (
        s_nd_input |=> dn.valid)
        else $error("non-decimating stage dropped a sample");
endmodule : ddchb_stage
